// ==== pmrc_pkg.sv ====
// Package of modes, reset targets and timing counts for the power mode and reset control block
package pmrc_pkg;

    // --------------------------------------------------------------
    // Power modes and reset targets
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        PMRC_MODE_FULL_ON,
        PMRC_MODE_DEEP_SLEEP,
        PMRC_MODE_HIBERNATE
    } pmrc_mode_t;

    typedef enum logic [1:0] {
        PMRC_TGT_NONE,
        PMRC_TGT_HARDWARE,
        PMRC_TGT_SYSTEM,
        PMRC_TGT_CORE
    } pmrc_target_t;

    // --------------------------------------------------------------
    // Timing
    // --------------------------------------------------------------
    localparam int unsigned PMRC_CLK_HZ = 20_000_000;
    // Least time the reset outputs stay asserted once a reset starts
    localparam int unsigned PMRC_RESET_HOLD_NS = 1000;
    localparam int unsigned PMRC_RESET_HOLD_CYC =
        (PMRC_RESET_HOLD_NS * (PMRC_CLK_HZ / 1_000_000) + 999) / 1000;
    // Least time the regulator is given to bring the core supply up
    localparam int unsigned PMRC_WAKE_SETTLE_NS = 10000;
    localparam int unsigned PMRC_WAKE_SETTLE_CYC =
        (PMRC_WAKE_SETTLE_NS * (PMRC_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned PMRC_CNT_W = 16;

    // --------------------------------------------------------------
    // Reset history bit positions
    // --------------------------------------------------------------
    localparam int unsigned PMRC_HIST_SW = 0;
    localparam int unsigned PMRC_HIST_PWR = 1;
    localparam int unsigned PMRC_HIST_EVT = 2;
    localparam int unsigned PMRC_HIST_TRIG = 3;
    localparam int unsigned PMRC_HIST_EMU = 4;
    localparam int unsigned PMRC_HIST_W = 5;
    localparam logic [PMRC_HIST_W-1:0] PMRC_HIST_RST = 5'h00;

endpackage

// ==== pmrc_regulator.sv ====
// Behavioural model of the core voltage regulator and the reset pin source
module pmrc_regulator #(
    parameter int unsigned RAMP_CYC = 3
) (
    input wire logic clk_i,
    input wire logic wake_i,
    input wire logic press_i,
    output logic core_power_on_o,
    output logic hw_reset_in_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Core supply
    // ------------------------------------------------------------
    int unsigned ramp = 0;
    // Supply needs a few cycles to come up, so a boot that does not wait is seen
    always @(posedge clk_i) begin
        if (wake_i !== 1'b1) begin
            ramp <= 0;
            core_power_on_o <= 1'b0;
        end else if (ramp < RAMP_CYC) begin
            ramp <= ramp + 1;
        end else begin
            core_power_on_o <= 1'b1;
        end
    end
    // Reset pin is driven by the source at all times, low while pressed
    assign hw_reset_in_n_o = !press_i;
endmodule

// ==== pmrc_sync.sv ====
// Two-flop synchroniser for a level from outside the clock domain
module pmrc_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic async_i,
    output logic sync_o
);
    logic stage1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            stage1 <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end
endmodule

// ==== pmrc_top.sv ====
// Power mode sequencer and reset target decision for the processor

// What this block does
// - After power-up the block sits in full-on with the PLL on, not bypassed, and all clocks enabled.
// - Deep sleep turns the PLL off and gates core, system, memory and peripheral clocks, power kept.
// - In deep sleep asynchronous peripherals are barred from internal resources and external memory.
// - Entering hibernate stops every clock and drops the regulator wake output.
// - In hibernate every external pin not given other behaviour is three-stated.
// - While a unit is in reset its control registers hold defaults and it stays idle.
// - Releasing a full system reset leaves the core ready to boot.
// - A hardware reset resets every unit, this control unit too, and clears the reset history.
// - A system reset resets every unit except this control unit, which keeps its contents.
// - The hardware reset input low starts a hardware reset.
// - Software, hibernate, event, trigger or emulator requests start a system reset.
// - The regulator wake output is high for core power-up and low for supply shutdown.
// - In hibernate the hardware reset input raises wake and then starts a boot sequence.
module pmrc_top #(
    parameter int unsigned RESET_HOLD_CYC = pmrc_pkg::PMRC_RESET_HOLD_CYC,
    parameter int unsigned WAKE_SETTLE_CYC = pmrc_pkg::PMRC_WAKE_SETTLE_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hw_reset_in_n_i,
    input wire logic sw_sys_reset_req_i,
    input wire logic sw_core_reset_req_i,
    input wire logic deep_sleep_req_i,
    input wire logic hibernate_req_i,
    input wire logic wake_req_i,
    input wire logic evt_reset_req_i,
    input wire logic trig_reset_req_i,
    input wire logic emu_reset_req_i,
    output pmrc_pkg::pmrc_mode_t mode_o,
    output logic pll_enable_o,
    output logic pll_bypass_o,
    output logic core_clk_en_o,
    output logic system_bus_clk_en_o,
    output logic memory_clk_en_o,
    output logic peripheral_clk_a_en_o,
    output logic peripheral_clk_b_en_o,
    output logic async_access_block_o,
    output logic regulator_wake_out_o,
    output logic pins_hiz_o,
    output logic hw_reset_o,
    output logic sys_reset_o,
    output logic core_reset_o,
    output logic core_boot_ready_o,
    output pmrc_pkg::pmrc_target_t last_target_o,
    output logic [pmrc_pkg::PMRC_HIST_W-1:0] reset_history_o
);
    import pmrc_pkg::*;

    // The counters are PMRC_CNT_W bits wide and must end at least one cycle in
    if (RESET_HOLD_CYC < 1 || RESET_HOLD_CYC >= (1 << PMRC_CNT_W)) begin : g_bad_hold
        $error("RESET_HOLD_CYC out of range");
    end
    if (WAKE_SETTLE_CYC < 1 || WAKE_SETTLE_CYC >= (1 << PMRC_CNT_W)) begin : g_bad_settle
        $error("WAKE_SETTLE_CYC out of range");
    end

    // ----------------------------------------------------------------
    // Pin synchronisation
    // ----------------------------------------------------------------
    logic hw_rst_n_sync;

    pmrc_sync #(
        .RESET_VAL(1'b1)
    ) u_hwrst_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(hw_reset_in_n_i),
        .sync_o(hw_rst_n_sync)
    );

    // ----------------------------------------------------------------
    // Sequencer state
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PMRC_ST_RUN,
        PMRC_ST_SLEEP,
        PMRC_ST_HIB,
        PMRC_ST_WAKE,
        PMRC_ST_RESET
    } pmrc_state_t;

    pmrc_state_t state;
    pmrc_state_t next_state;
    pmrc_target_t target;
    pmrc_target_t next_target;
    logic [PMRC_CNT_W-1:0] count;
    logic [PMRC_CNT_W-1:0] next_count;
    logic [PMRC_HIST_W-1:0] history;
    logic [PMRC_HIST_W-1:0] next_history;
    logic boot_ready;

    localparam logic [PMRC_CNT_W-1:0] HOLD_LAST = PMRC_CNT_W'(RESET_HOLD_CYC - 1);
    localparam logic [PMRC_CNT_W-1:0] WAKE_LAST = PMRC_CNT_W'(WAKE_SETTLE_CYC - 1);

    // ----------------------------------------------------------------
    // Request decoding
    // ----------------------------------------------------------------
    wire hw_req = !hw_rst_n_sync;
    wire [PMRC_HIST_W-1:0] sys_src = {
        emu_reset_req_i,
        trig_reset_req_i,
        evt_reset_req_i,
        1'b0,
        sw_sys_reset_req_i
    };
    wire sys_req = |sys_src;
    wire count_done_hold = (count == HOLD_LAST);
    wire count_done_wake = (count == WAKE_LAST);
    wire in_reset = (state == PMRC_ST_RESET);

    // Hibernate is recorded as a power manager source; the boot that follows
    // it is a system reset so this unit keeps its history across the wake.
    always_comb begin
        next_state = state;
        next_target = target;
        next_count = count;
        next_history = history;
        if (hw_req && state != PMRC_ST_HIB && state != PMRC_ST_WAKE) begin
            next_state = PMRC_ST_RESET;
            next_target = PMRC_TGT_HARDWARE;
            next_count = '0;
            next_history = PMRC_HIST_RST;
        end else begin
            unique case (state)
                PMRC_ST_RUN: begin
                    if (sys_req) begin
                        next_state = PMRC_ST_RESET;
                        next_target = PMRC_TGT_SYSTEM;
                        next_count = '0;
                        next_history = history | sys_src;
                    end else if (hibernate_req_i) begin
                        next_state = PMRC_ST_HIB;
                        next_history = history | (PMRC_HIST_W'(1) << PMRC_HIST_PWR);
                    end else if (deep_sleep_req_i) begin
                        next_state = PMRC_ST_SLEEP;
                    end else if (sw_core_reset_req_i) begin
                        next_state = PMRC_ST_RESET;
                        next_target = PMRC_TGT_CORE;
                        next_count = '0;
                    end
                end
                PMRC_ST_SLEEP: begin
                    if (sys_req) begin
                        next_state = PMRC_ST_RESET;
                        next_target = PMRC_TGT_SYSTEM;
                        next_count = '0;
                        next_history = history | sys_src;
                    end else if (hibernate_req_i) begin
                        next_state = PMRC_ST_HIB;
                        next_history = history | (PMRC_HIST_W'(1) << PMRC_HIST_PWR);
                    end else if (wake_req_i) begin
                        next_state = PMRC_ST_RUN;
                    end
                end
                PMRC_ST_HIB: begin
                    // Only the reset pin can end hibernate; the core is unpowered
                    if (hw_req) begin
                        next_state = PMRC_ST_WAKE;
                        next_count = '0;
                    end
                end
                PMRC_ST_WAKE: begin
                    next_count = count + 1'b1;
                    if (count_done_wake) begin
                        next_state = PMRC_ST_RESET;
                        next_target = PMRC_TGT_SYSTEM;
                        next_count = '0;
                    end
                end
                PMRC_ST_RESET: begin
                    // A held pin keeps the reset going through the branch above
                    next_count = count_done_hold ? count : count + 1'b1;
                    if (count_done_hold) begin
                        next_state = PMRC_ST_RUN;
                    end
                end
                default: begin
                    next_state = PMRC_ST_RUN;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= PMRC_ST_RUN;
            target <= PMRC_TGT_NONE;
            count <= '0;
            history <= PMRC_HIST_RST;
            boot_ready <= 1'b0;
        end else begin
            state <= next_state;
            target <= next_target;
            count <= next_count;
            history <= next_history;
            boot_ready <= (in_reset && count_done_hold && target != PMRC_TGT_CORE)
                ? 1'b1 : (next_state == PMRC_ST_RESET ? 1'b0 : boot_ready);
        end
    end

    // ----------------------------------------------------------------
    // Output decoding
    // ----------------------------------------------------------------
    wire clk_run = (state == PMRC_ST_RUN) || (in_reset && target == PMRC_TGT_CORE);
    wire full_rst = in_reset && target != PMRC_TGT_CORE;
    wire hib = (state == PMRC_ST_HIB);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_o <= PMRC_MODE_FULL_ON;
            pll_enable_o <= 1'b1;
            pll_bypass_o <= 1'b0;
            core_clk_en_o <= 1'b1;
            system_bus_clk_en_o <= 1'b1;
            memory_clk_en_o <= 1'b1;
            peripheral_clk_a_en_o <= 1'b1;
            peripheral_clk_b_en_o <= 1'b1;
            async_access_block_o <= 1'b0;
            regulator_wake_out_o <= 1'b1;
            pins_hiz_o <= 1'b0;
            hw_reset_o <= 1'b1;
            sys_reset_o <= 1'b1;
            core_reset_o <= 1'b1;
        end else begin
            mode_o <= (state == PMRC_ST_SLEEP) ? PMRC_MODE_DEEP_SLEEP :
                (hib || state == PMRC_ST_WAKE) ? PMRC_MODE_HIBERNATE : PMRC_MODE_FULL_ON;
            pll_enable_o <= clk_run || full_rst;
            pll_bypass_o <= 1'b0;
            core_clk_en_o <= (state == PMRC_ST_RUN);
            system_bus_clk_en_o <= clk_run || full_rst;
            memory_clk_en_o <= clk_run || full_rst;
            peripheral_clk_a_en_o <= clk_run || full_rst;
            peripheral_clk_b_en_o <= clk_run || full_rst;
            async_access_block_o <= (state == PMRC_ST_SLEEP);
            regulator_wake_out_o <= !hib;
            pins_hiz_o <= hib;
            hw_reset_o <= in_reset && target == PMRC_TGT_HARDWARE;
            sys_reset_o <= full_rst;
            core_reset_o <= in_reset || hib || state == PMRC_ST_WAKE;
        end
    end

    assign core_boot_ready_o = boot_ready;
    assign last_target_o = target;
    assign reset_history_o = history;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_hib_wake_low;
        @(posedge clk_i) disable iff (rst_i)
        (state == PMRC_ST_HIB) |=> !regulator_wake_out_o && pins_hiz_o && !core_clk_en_o;
    endproperty
    a_hib_wake_low: assert property (p_hib_wake_low) else $error("wake not low in hibernate");

    property p_sleep_gated;
        @(posedge clk_i) disable iff (rst_i)
        (state == PMRC_ST_SLEEP) |=> !pll_enable_o && !memory_clk_en_o && regulator_wake_out_o;
    endproperty
    a_sleep_gated: assert property (p_sleep_gated) else $error("clocks run in deep sleep");

    property p_sleep_block;
        @(posedge clk_i) disable iff (rst_i)
        $rose(state == PMRC_ST_SLEEP) |=> async_access_block_o;
    endproperty
    a_sleep_block: assert property (p_sleep_block) else $error("async access open in sleep");

    property p_pin_reset;
        @(posedge clk_i) disable iff (rst_i)
        (!hw_reset_in_n_i && state == PMRC_ST_RUN) [*3] |=> ##1 hw_reset_o && history == '0;
    endproperty
    a_pin_reset: assert property (p_pin_reset) else $error("pin low gave no hardware reset");

    property p_sys_reset;
        @(posedge clk_i) disable iff (rst_i)
        (state == PMRC_ST_RUN && hw_rst_n_sync && evt_reset_req_i) |=> ##1 sys_reset_o && !hw_reset_o;
    endproperty
    a_sys_reset: assert property (p_sys_reset) else $error("event gave no system reset");

    property p_hist_kept;
        @(posedge clk_i) disable iff (rst_i)
        (in_reset && target == PMRC_TGT_SYSTEM && !hw_req) |=> history == $past(history);
    endproperty
    a_hist_kept: assert property (p_hist_kept) else $error("history lost in system reset");

    property p_hib_wake;
        @(posedge clk_i) disable iff (rst_i)
        (hib && hw_req) |=> ##1 regulator_wake_out_o && core_reset_o;
    endproperty
    a_hib_wake: assert property (p_hib_wake) else $error("pin did not wake regulator");

    property p_boot;
        @(posedge clk_i) disable iff (rst_i)
        (in_reset && count_done_hold && target == PMRC_TGT_SYSTEM && !hw_req)
            |=> ##1 core_boot_ready_o && !sys_reset_o;
    endproperty
    a_boot: assert property (p_boot) else $error("core not ready after reset");

    property p_reg_rise;
        @(posedge clk_i) disable iff (rst_i)
        $rose(mode_o == PMRC_MODE_DEEP_SLEEP) |-> $past(state) == PMRC_ST_SLEEP;
    endproperty
    a_reg_rise: assert property (p_reg_rise) else $error("mode not registered");
endmodule

// ==== power_mode_reset_control_bench.sv ====
// Self-checking bench for the power mode and reset control block
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin fails++; \
    $display("ERROR %s expected %0h seen %0h", nm, exp, got); end end
`define WAIT_FOR(c, lim) for (int k = 0; k < (lim) && !(c); k++) @(negedge clk_i);
module power_mode_reset_control_bench;
    import pmrc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    localparam int HOLD = 4;
    localparam int SETTLE = 6;
    localparam logic [PMRC_HIST_W-1:0] HIST_SRC = PMRC_HIST_W'((1 << PMRC_HIST_SW)
        | (1 << PMRC_HIST_EVT) | (1 << PMRC_HIST_TRIG) | (1 << PMRC_HIST_EMU));
    localparam logic [PMRC_HIST_W-1:0] HIST_ALL = HIST_SRC | PMRC_HIST_W'(1 << PMRC_HIST_PWR);
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic press = 1'b0;
    logic core_req = 1'b0;
    logic ds_req = 1'b0;
    logic hib_req = 1'b0;
    logic wake_req = 1'b0;
    logic [3:0] src_req = 4'h0;
    pmrc_mode_t mode;
    pmrc_target_t tgt;
    logic pll_en, pll_byp, core_en, bus_en, mem_en, pa_en, pb_en, blk, wake_out, hiz;
    logic hw_rst, sys_rst, core_rst, boot_rdy, hw_n, pwr_on;
    logic [PMRC_HIST_W-1:0] hist;
    wire [4:0] clk_ens = {core_en, bus_en, mem_en, pa_en, pb_en};
    int fails = 0;
    int n_compared = 0;
    always #25 clk_i = ~clk_i;
    pmrc_top #(.RESET_HOLD_CYC(HOLD), .WAKE_SETTLE_CYC(SETTLE)) u_pmrc_top (
        .clk_i(clk_i), .rst_i(rst_i), .hw_reset_in_n_i(hw_n),
        .sw_sys_reset_req_i(src_req[0]), .sw_core_reset_req_i(core_req),
        .deep_sleep_req_i(ds_req), .hibernate_req_i(hib_req), .wake_req_i(wake_req),
        .evt_reset_req_i(src_req[1]), .trig_reset_req_i(src_req[2]),
        .emu_reset_req_i(src_req[3]), .mode_o(mode), .pll_enable_o(pll_en),
        .pll_bypass_o(pll_byp), .core_clk_en_o(core_en), .system_bus_clk_en_o(bus_en),
        .memory_clk_en_o(mem_en), .peripheral_clk_a_en_o(pa_en),
        .peripheral_clk_b_en_o(pb_en), .async_access_block_o(blk),
        .regulator_wake_out_o(wake_out), .pins_hiz_o(hiz), .hw_reset_o(hw_rst),
        .sys_reset_o(sys_rst), .core_reset_o(core_rst), .core_boot_ready_o(boot_rdy),
        .last_target_o(tgt), .reset_history_o(hist));
    pmrc_regulator u_pmrc_regulator (.clk_i(clk_i), .wake_i(wake_out), .press_i(press),
        .core_power_on_o(pwr_on), .hw_reset_in_n_o(hw_n));
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_defaults;
        `CHK("mode", PMRC_MODE_FULL_ON, mode)
        `CHK("pll", 2'b10, {pll_en, pll_byp})
        `CHK("clocks", 5'h1F, clk_ens)
        `CHK("wake_hiz", 2'b10, {wake_out, hiz})
        `CHK("resets", 3'h0, {hw_rst, sys_rst, core_rst})
        `CHK("history", PMRC_HIST_RST, hist)
    endtask
    task t_deep_sleep;
        @(negedge clk_i) ds_req = 1'b1;
        @(negedge clk_i) ds_req = 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK("mode", PMRC_MODE_DEEP_SLEEP, mode)
        `CHK("pll_clocks", 6'h00, {pll_en, clk_ens})
        `CHK("wake", 1'b1, wake_out)
        `CHK("block", 1'b1, blk)
        @(negedge clk_i) wake_req = 1'b1;
        @(negedge clk_i) wake_req = 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK("mode", PMRC_MODE_FULL_ON, mode)
        `CHK("block_clocks", 6'h1F, {blk, clk_ens})
    endtask
    task t_sources;
        int pos[4];
        logic [PMRC_HIST_W-1:0] exp;
        pos = '{PMRC_HIST_SW, PMRC_HIST_EVT, PMRC_HIST_TRIG, PMRC_HIST_EMU};
        exp = PMRC_HIST_RST;
        for (int i = 0; i < 4; i++) begin
            // A deep sleep request at the same edge must lose to the reset
            @(negedge clk_i) src_req = 4'h1 << i;
            ds_req = (i == 0);
            @(negedge clk_i) src_req = 4'h0;
            ds_req = 1'b0;
            `WAIT_FOR(sys_rst === 1'b1, 4)
            exp[pos[i]] = 1'b1;
            `CHK("sys_reset", 1'b1, sys_rst)
            `CHK("hw_reset", 1'b0, hw_rst)
            `CHK("core_clk", 1'b0, core_en)
            `WAIT_FOR(sys_rst === 1'b0, HOLD + 4)
            @(negedge clk_i);
            `CHK("target", PMRC_TGT_SYSTEM, tgt)
            `CHK("history", exp, hist)
            `CHK("boot_ready", 1'b1, boot_rdy)
            `CHK("mode", PMRC_MODE_FULL_ON, mode)
        end
    endtask
    task t_sleep_reset;
        // A system reset request must also be taken while in deep sleep
        @(negedge clk_i) ds_req = 1'b1;
        @(negedge clk_i) ds_req = 1'b0;
        src_req = 4'h4;
        @(negedge clk_i) src_req = 4'h0;
        `WAIT_FOR(sys_rst === 1'b1, 4)
        `CHK("sleep_sys_reset", 2'h2, {sys_rst, blk})
        `WAIT_FOR(sys_rst === 1'b0, HOLD + 4)
        @(negedge clk_i);
        `CHK("sleep_mode", PMRC_MODE_FULL_ON, mode)
        `CHK("sleep_boot", 1'b1, boot_rdy)
        `CHK("sleep_history", HIST_SRC, hist)
    endtask
    task t_core_reset;
        // No core traffic is pending in this bench when the request goes out
        @(negedge clk_i) core_req = 1'b1;
        @(negedge clk_i) core_req = 1'b0;
        `WAIT_FOR(core_rst === 1'b1, 4)
        `CHK("resets", 3'b100, {core_rst, sys_rst, hw_rst})
        `CHK("clocks", 5'h0F, clk_ens)
        `WAIT_FOR(core_rst === 1'b0, HOLD + 4)
        @(negedge clk_i);
        `CHK("target", PMRC_TGT_CORE, tgt)
        `CHK("history", HIST_SRC, hist)
    endtask
    task t_hibernate;
        // Internal state counts as saved before the request
        @(negedge clk_i) hib_req = 1'b1;
        @(negedge clk_i) hib_req = 1'b0;
        repeat (2) @(negedge clk_i);
        `CHK("mode", PMRC_MODE_HIBERNATE, mode)
        `CHK("pll_clocks", 6'h00, {pll_en, clk_ens})
        `CHK("wake_hiz", 2'b01, {wake_out, hiz})
        repeat (3) @(negedge clk_i);
        `CHK("supply", 1'b0, pwr_on)
        @(negedge clk_i) press = 1'b1;
        `WAIT_FOR(wake_out === 1'b1, 6)
        @(negedge clk_i) press = 1'b0;
        `CHK("wake_first", 2'b10, {wake_out, sys_rst})
        `WAIT_FOR(sys_rst === 1'b1, SETTLE + 6)
        `CHK("boot_reset", 3'b110, {sys_rst, pwr_on, hw_rst})
        `WAIT_FOR(sys_rst === 1'b0, HOLD + 4)
        @(negedge clk_i);
        `CHK("mode", PMRC_MODE_FULL_ON, mode)
        `CHK("wake_hiz_boot", 3'b101, {wake_out, hiz, boot_rdy})
        `CHK("history", HIST_ALL, hist)
    endtask
    task t_hw_reset;
        @(negedge clk_i) press = 1'b1;
        @(negedge clk_i);
        `CHK("pin_sync", 1'b0, hw_rst)
        `WAIT_FOR(hw_rst === 1'b1, 6)
        `CHK("hw_reset", 2'b10, {hw_rst, core_en})
        `CHK("history", PMRC_HIST_RST, hist)
        repeat (HOLD + 3) @(negedge clk_i);
        `CHK("held", 1'b1, hw_rst)
        @(negedge clk_i) press = 1'b0;
        `WAIT_FOR(hw_rst === 1'b0, HOLD + 6)
        @(negedge clk_i);
        `CHK("target", PMRC_TGT_HARDWARE, tgt)
        `CHK("boot_ready", 1'b1, boot_rdy)
        `CHK("history", PMRC_HIST_RST, hist)
    endtask
    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task stop_test;
        if (fails == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        // The run needs well under a thousand cycles; this margin only catches a hang
        #(20000 * 50);
        fails++;
        stop_test();
    end
    initial begin
        repeat (16) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
        t_defaults();
        t_deep_sleep();
        t_sources();
        t_sleep_reset();
        t_core_reset();
        t_hibernate();
        t_hw_reset();
        stop_test();
    end
endmodule
